/* File: default_start_watchdog_tb.sv */
module default_start_watchdog_tb;
  import dsw_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, fix = 0, stab = 0;
  logic [31:0] awa = 0, wd = 0, ara = 0, rdata;
  logic [3:0] ws = 0;
  logic [1:0] bresp, rresp, r;
  logic awr, wr_, bv, arr, rv, rreq, nreq, cpu;
  logic [1:0] tc = 0;
  logic tk, tk_q = 0;
  int fail_count = 0, n_checks = 0, n_rst, n_nmi, t, e, b_r = 0, b_n = 0;
  bit got;
  logic [7:0] m;
  assign tk = tc[1];
  always #2.5 aclk = ~aclk;
  always @(posedge aclk)
  begin
    tc <= tc + 2'h1;
    tk_q <= tk;
  end
  dsw_watchdog dut (.aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .intosc_tick(tk),
    .mainclk_tick(tk), .subclk_tick(tk), .optbyte_wd_fix(fix), .osc_stabilising(stab),
    .wd_reset_request(rreq), .wd_nmi_request(nreq), .cpu_clk_to_intosc(cpu));
  dsw_far far (.aclk, .rst_req(rreq), .nmi_req(nreq), .n_rst, .n_nmi);
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task close_out();
    $display("checks %0d mismatches %0d resets %0d nmis %0d", n_checks, fail_count, n_rst, n_nmi);
    if (fail_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    b_r = n_rst;
    b_n = n_nmi;
    awa <= a; wd <= d; ws <= s; awv <= 1; wv <= 1; br <= 1;
    for (int i = 0; i < 60; i++)
    begin
      @(posedge aclk);
      if (awr) awv <= 0;
      if (wr_) wv <= 0;
      if (bv) begin r = bresp; br <= 0; @(posedge aclk); return; end
    end
    chk(0, 1);
    close_out();
  endtask
  task rd(input logic [31:0] a, input logic [31:0] x, input logic [1:0] xr);
    ara <= a; arv <= 1; rr <= 1;
    for (int i = 0; i < 60; i++)
    begin
      @(posedge aclk);
      if (arr) arv <= 0;
      if (rv) begin chk({rresp, rdata}, {xr, x}); rr <= 0; @(posedge aclk); return; end
    end
    chk(0, 1);
    close_out();
  endtask
  task rst();
    aresetn <= 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    repeat (3) @(posedge aclk);
  endtask
  task wait_req(input int lim);
    t = 0;
    got = 0;
    for (int i = 0; i < lim && !got; i++)
    begin
      @(posedge aclk);
      if (tk && !tk_q) t++;
      got = (n_rst != b_r) || (n_nmi != b_n);
    end
    r = {n_rst != b_r, n_nmi != b_n};
  endtask
  function automatic int period(input logic [7:0] v);
    return 1 << ((v[4] ? 9 : v[3] ? 18 : 12) + v[2:0]);
  endfunction
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h57b18f59));
    rst();
    rd(MODE_PERIOD_ADDR, 32'h67, RESP_OKAY);
    wr(RESTART_ADDR, RESTART_CODE, 4'h1);
    rd(RESTART_ADDR, 32'h9a, RESP_OKAY);
    rd(STATUS_ADDR + 32'h4, 32'h0, RESP_SLVERR);
    wr(STATUS_ADDR + 32'h4, 32'h0, 4'h1);
    chk(r, RESP_SLVERR);
    wr(RESTART_ADDR, 32'h55, 4'h1);
    wait_req(60);
    chk({got, r}, 3'b110);
    $display("test 1 done");
    rst();
    wr(RESTART_ADDR, 32'h1ac, 4'h1);
    wait_req(60);
    chk({got, r}, 3'b110);
    $display("test 2 done");
    for (int k = 0; k < 3; k++)
    begin
      m = (k == 0) ? 8'h40 : 8'h30 | 8'($urandom % 2);
      e = period(m);
      rst();
      wr(MODE_PERIOD_ADDR, 32'h0, 4'hf);
      wr(MODE_PERIOD_ADDR, m, 4'h1);
      rd(MODE_PERIOD_ADDR, m, RESP_OKAY);
      repeat (e * 2) @(posedge aclk);
      wr(RESTART_ADDR, RESTART_CODE, 4'h1);
      wait_req(e * 5);
      chk(got && t >= e - 3 && t <= e + 3, 1);
      chk(r, m[6] ? 2'b10 : 2'b01);
      repeat (30) @(posedge aclk);
      wr(MODE_PERIOD_ADDR, 32'h0, 4'h1);
      wait_req(60);
      chk(got, 1);
      rd(MODE_PERIOD_ADDR, m, RESP_OKAY);
    end
    $display("test 3 done");
    rst();
    wr(MODE_PERIOD_ADDR, 32'h0, 4'h1);
    wr(RESTART_ADDR, 32'h55, 4'h1);
    wr(MODE_PERIOD_ADDR, 32'h67, 4'h1);
    wait_req(300);
    chk(got, 0);
    rd(MODE_PERIOD_ADDR, 32'h0, RESP_OKAY);
    $display("test 4 done");
    fix <= 1;
    rst();
    wr(MODE_PERIOD_ADDR, 32'h2b, 4'h1);
    rd(MODE_PERIOD_ADDR, 32'h63, RESP_OKAY);
    stab <= 1;
    repeat (4) @(posedge aclk);
    wr(RESTART_ADDR, 32'h55, 4'h1);
    repeat (40) @(posedge aclk);
    chk({cpu, rreq}, 2'b10);
    stab <= 0;
    repeat (40) @(posedge aclk);
    wr(RESTART_ADDR, 32'h0, 4'h1);
    wait_req(60);
    chk({got, r}, 3'b110);
    $display("test 5 done");
    close_out();
  end
endmodule

/* File: dsw_chk.sv */
module dsw_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        optbyte_wd_fix,
  input wire logic        wd_reset_request,
  input wire logic        wd_nmi_request,
  input wire logic        cpu_clk_to_intosc
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence quiet_s;
    !wd_reset_request && !wd_nmi_request;
  endsequence
  quiet_start_a: assert property ($rose(aresetn) |-> quiet_s [*3])
    else $error("request right after reset");
  req_excl_a: assert property (!(wd_reset_request && wd_nmi_request))
    else $error("both requests high");
  fix_nmi_a: assert property ($rose(wd_nmi_request) |-> !$past(optbyte_wd_fix, 4))
    else $error("nmi while strap fixed");
  clk_sticky_a: assert property (cpu_clk_to_intosc |=> cpu_clk_to_intosc)
    else $error("clock switch flag dropped");
  stab_no_rst_a: assert property ($rose(cpu_clk_to_intosc) |-> !wd_reset_request)
    else $error("reset during stabilisation");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  awready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held");
endmodule

bind dsw_watchdog dsw_chk chk (.aclk, .aresetn, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .optbyte_wd_fix,
  .wd_reset_request, .wd_nmi_request, .cpu_clk_to_intosc);

/* File: dsw_far.sv */
module dsw_far (
  input wire logic aclk,
  input wire logic rst_req,
  input wire logic nmi_req,
  output int       n_rst,
  output int       n_nmi
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rst_q = 1'b0;
  logic nmi_q = 1'b0;
  initial n_rst = 0;
  initial n_nmi = 0;
  // counts outlive block resets, as the reset generator does
  always @(posedge aclk)
  begin
    rst_q <= rst_req;
    nmi_q <= nmi_req;
    if (rst_req && !rst_q) n_rst <= n_rst + 1;
    if (nmi_req && !nmi_q) n_nmi <= n_nmi + 1;
  end
endmodule

/* File: dsw_pkg.sv */
package dsw_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [31:0] MODE_PERIOD_ADDR  = 32'hfffff6d0;
  localparam logic [31:0] RESTART_ADDR      = 32'hfffff6d4;
  localparam logic [31:0] STATUS_ADDR       = 32'hfffff6d8;
  localparam logic [7:0]  MODE_PERIOD_RST   = 8'h67;
  localparam logic [7:0]  RESTART_READ_VAL  = 8'h9a;
  localparam logic [7:0]  RESTART_CODE      = 8'hac;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MODE_SEL_HI_BIT    = 6;
  localparam int MODE_SEL_LO_BIT    = 5;
  localparam int CLK_SRC_SEL_HI_BIT = 4;
  localparam int CLK_SRC_SEL_LO_BIT = 3;
  localparam int PERIOD_SEL_MSB     = 2;
  localparam int BIT_ACCESS_BIT     = 8;

  // ----------------------------------------------------------------
  // period exponents and counter width
  // ----------------------------------------------------------------
  localparam logic [4:0] EXP_BASE_INTOSC = 5'h0c;
  localparam logic [4:0] EXP_BASE_MAIN   = 5'h12;
  localparam logic [4:0] EXP_BASE_SUB    = 5'h09;
  localparam int         CNT_W           = 26;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {DSW_SRC_INTOSC, DSW_SRC_MAIN, DSW_SRC_SUB} dsw_src_e;

endpackage

/* File: dsw_watchdog.sv */
// Function
// - mode register writable once, readable always
// - mode register resets to 67h
// - mode 00 stop, 01 nmi, 1x reset
// - fix strap forces reset mode, internal oscillator
// - second mode write forces overflow, clears counter
// - restart byte other than ACh forces overflow
// - bit access to restart forces overflow
// - stopped mode suppresses forced overflows
// - ACh to restart clears counter
// - restart register always reads 9Ah
// - counts in reset mode after reset release
// - internal oscillator period 2^(12+n)
// - main 2^(18+n), subclock 2^(9+n)
// - mode register written by byte only
// - running mode cannot be stopped later
// - overflow raises reset or nmi request
// - reset-mode overflow during stabilisation switches cpu clock
module dsw_watchdog
  import dsw_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        intosc_tick,
  input  wire logic        mainclk_tick,
  input  wire logic        subclk_tick,
  input  wire logic        optbyte_wd_fix,
  input  wire logic        osc_stabilising,
  output logic             wd_reset_request,
  output logic             wd_nmi_request,
  output logic             cpu_clk_to_intosc
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic       tick_prev_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end
    else
    begin
      sync1_q <= {osc_stabilising, optbyte_wd_fix, subclk_tick, mainclk_tick, intosc_tick};
      sync2_q <= sync1_q;
    end
  end

  logic [7:0] mode_period_q;
  logic       mode_written_q;
  logic [7:0] eff_cfg;
  dsw_src_e   src;
  logic       src_tick;
  logic       tick_edge;

  // the fix strap overrides the stored mode and clock source bits on every read and use
  always_comb
  begin
    eff_cfg = mode_period_q;
    if (sync2_q[3])
    begin
      eff_cfg[MODE_SEL_HI_BIT]    = 1'b1;
      eff_cfg[MODE_SEL_LO_BIT]    = 1'b1;
      eff_cfg[CLK_SRC_SEL_HI_BIT] = 1'b0;
      eff_cfg[CLK_SRC_SEL_LO_BIT] = 1'b0;
    end
  end

  always_comb
  begin
    if (eff_cfg[CLK_SRC_SEL_HI_BIT])
      src = DSW_SRC_SUB;
    else if (eff_cfg[CLK_SRC_SEL_LO_BIT])
      src = DSW_SRC_MAIN;
    else
      src = DSW_SRC_INTOSC;
  end

  always_comb
  begin
    case (src)
      DSW_SRC_SUB:  src_tick = sync2_q[2];
      DSW_SRC_MAIN: src_tick = sync2_q[1];
      default:      src_tick = sync2_q[0];
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick_prev_q <= 1'b0;
    else
      tick_prev_q <= src_tick;
  end

  // one flop of history is enough because every tick level lasts at least two cycles
  assign tick_edge = src_tick && !tick_prev_q;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] period_exp(input logic [7:0] cfg);
    logic [4:0] base;
    base = EXP_BASE_INTOSC;
    if (cfg[CLK_SRC_SEL_HI_BIT])
      base = EXP_BASE_SUB;
    else if (cfg[CLK_SRC_SEL_LO_BIT])
      base = EXP_BASE_MAIN;
    return base + {2'b00, cfg[PERIOD_SEL_MSB:0]};
  endfunction

  function automatic logic is_stopped(input logic [7:0] cfg);
    return !cfg[MODE_SEL_HI_BIT] && !cfg[MODE_SEL_LO_BIT];
  endfunction

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        aw_held_q;
  logic        w_held_q;
  logic        wr_go;
  logic        wr_mode;
  logic        wr_restart;
  logic        wr_byte0;
  logic        wr_bad;

  // the write is acted on only once both halves are held and no response is pending
  assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;

  // each ready is a one-cycle pulse, so a standing offer is never taken twice
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_axi_awready <= 1'b0;
    else
      s_axi_awready <= !aw_held_q && !s_axi_awready && !(s_axi_awvalid && s_axi_awready);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_axi_wready <= 1'b0;
    else
      s_axi_wready <= !w_held_q && !s_axi_wready && !(s_axi_wvalid && s_axi_wready);
  end

  // the address waits here until its data has arrived as well
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      awaddr_q  <= 32'h00000000;
    end
    else if (wr_go)
      aw_held_q <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_q <= 1'b0;
      wdata_q  <= 32'h00000000;
      wstrb_q  <= 4'h0;
    end
    else if (wr_go)
      w_held_q <= 1'b0;
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end
  end

  // unmapped writes are answered with an error and change nothing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_mode || wr_restart) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_comb
  begin
    wr_mode    = 1'b0;
    wr_restart = 1'b0;
    if (awaddr_q == MODE_PERIOD_ADDR)
      wr_mode = wr_go;
    else if (awaddr_q == RESTART_ADDR)
      wr_restart = wr_go;
  end

  // only lane 0 alone is a byte write; wider strobes model other access sizes
  assign wr_byte0 = (wstrb_q == 4'h1);
  // wdata bit 8 on a restart write marks a single-bit manipulation
  assign wr_bad = wr_restart && (wdata_q[BIT_ACCESS_BIT] || wdata_q[7:0] != RESTART_CODE);

  // ----------------------------------------------------------------
  // mode and period register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_period_q  <= MODE_PERIOD_RST;
      mode_written_q <= 1'b0;
    end
    else if (wr_mode && wr_byte0)
    begin
      mode_written_q <= 1'b1;
      if (!mode_written_q)
        mode_period_q <= {1'b0, wdata_q[6:0]};
      // later writes never touch the setting, so a running timer stays running
    end
  end

  // ----------------------------------------------------------------
  // counter and overflow
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] count_q;
  logic             forced;
  logic             natural_ovf;
  logic             clear_cnt;
  logic             overflow;

  assign forced = !is_stopped(eff_cfg) &&
                  ((wr_mode && wr_byte0 && mode_written_q) || wr_bad);
  assign natural_ovf = !is_stopped(eff_cfg) && tick_edge &&
                       (count_q == CNT_W'((1 << period_exp(eff_cfg)) - 1));
  assign clear_cnt = forced || (wr_restart && !wr_bad) || natural_ovf;
  assign overflow = forced || natural_ovf;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_q <= '0;
    else if (clear_cnt)
      count_q <= '0;
    else if (!is_stopped(eff_cfg) && tick_edge)
      count_q <= count_q + 1'b1;
  end

  // requests are held from the overflow until the next selected tick edge
  logic pulse_q;

  // a new overflow wins over the end of the previous pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pulse_q          <= 1'b0;
      wd_reset_request <= 1'b0;
      wd_nmi_request   <= 1'b0;
    end
    else if (overflow)
    begin
      pulse_q <= 1'b1;
      if (eff_cfg[MODE_SEL_HI_BIT] && !sync2_q[4])
        wd_reset_request <= 1'b1;
      else if (!eff_cfg[MODE_SEL_HI_BIT])
        wd_nmi_request <= 1'b1;
    end
    else if (pulse_q && tick_edge)
    begin
      pulse_q          <= 1'b0;
      wd_reset_request <= 1'b0;
      wd_nmi_request   <= 1'b0;
    end
  end

  // the clock switch replaces the reset and stays until the next block reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cpu_clk_to_intosc <= 1'b0;
    else if (overflow && eff_cfg[MODE_SEL_HI_BIT] && sync2_q[4])
      cpu_clk_to_intosc <= 1'b1;
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  // no new address is taken while read data still waits for the master
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_axi_arready <= 1'b0;
    else
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        if (s_axi_araddr == MODE_PERIOD_ADDR)
          s_axi_rdata <= {24'h000000, eff_cfg};
        else if (s_axi_araddr == RESTART_ADDR)
          s_axi_rdata <= {24'h000000, RESTART_READ_VAL};
        else if (s_axi_araddr == STATUS_ADDR)
          s_axi_rdata <= {5'h00, count_q, mode_written_q};
        else
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= RESP_SLVERR;
        end
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule
